// file: logic/adc_cfg_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: Avalon-MM slave with 32-bit data, byte addresses, word aligned
// Notes: register bits above the listed fields read as zero
package adc_cfg_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned RES_W = 10;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL0 = 5'h00;
    localparam logic [4:0] OFS_CTRL1 = 5'h04;
    localparam logic [4:0] OFS_IRQ = 5'h08;
    localparam logic [4:0] OFS_RES_HIGH = 5'h0c;
    localparam logic [4:0] OFS_RES_LOW = 5'h10;

    // control_reg_zero fields
    localparam int unsigned POS_ON = 0;
    localparam int unsigned POS_GO = 1;
    localparam int unsigned POS_CHAN = 2;
    localparam int unsigned POS_REF = 6;
    localparam int unsigned POS_JUSTIFY = 7;
    // control_reg_one fields
    localparam int unsigned POS_CLKSEL = 4;
    // flag register fields
    localparam int unsigned POS_DONE = 0;
    localparam int unsigned POS_IE = 1;

    // reset values
    localparam logic [2:0] RST_CHAN = 3'h0;
    localparam logic [2:0] RST_CLKSEL = 3'h0;
    localparam logic RST_REF = 1'b0;
    localparam logic RST_JUSTIFY = 1'b0;
    localparam logic RST_ON = 1'b0;

    // conversion clock select encodings
    localparam logic [2:0] SEL_DIV2 = 3'h0;
    localparam logic [2:0] SEL_DIV4 = 3'h4;
    localparam logic [2:0] SEL_DIV8 = 3'h1;
    localparam logic [2:0] SEL_DIV16 = 3'h5;
    localparam logic [2:0] SEL_DIV32 = 3'h2;
    localparam logic [2:0] SEL_DIV64 = 3'h6;

    // divider terminal counts (division minus one)
    localparam logic [5:0] TERM_DIV2 = 6'h01;
    localparam logic [5:0] TERM_DIV4 = 6'h03;
    localparam logic [5:0] TERM_DIV8 = 6'h07;
    localparam logic [5:0] TERM_DIV16 = 6'h0f;
    localparam logic [5:0] TERM_DIV32 = 6'h1f;
    localparam logic [5:0] TERM_DIV64 = 6'h3f;

    // bit periods per conversion and after an abort
    localparam logic [3:0] CONV_PERIODS = 4'hb;
    localparam logic [3:0] HOLD_PERIODS = 4'h2;

    typedef enum logic [1:0] {PH_OFF, PH_ACQ, PH_CONV, PH_HOLD} phase_e;

endpackage

// file: logic/tad_if.sv
// Purpose: carries the bit period request and tick between control and divider
// Assumes: single clock domain
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
interface tad_if;
    logic run;
    logic [2:0] sel;
    logic tick;
    modport ctrl (output run, output sel, input tick);
    modport div (input run, input sel, output tick);
endinterface

// file: logic/conv_clock_div.sv
// Purpose: bit period tick from the system clock or the dedicated rc tick
// Assumes: rc_tick is a synchronous one-cycle pulse
// Notes: counter restarts whenever run is low
`timescale 1ns/1ps
module conv_clock_div
    import adc_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_sync_n,
    input wire logic clk_en,
    input wire logic rc_tick,
    tad_if.div tad
);
    import adc_cfg_pkg::*;

    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } div_s;

    div_s st_q;
    div_s st_d;
    logic [5:0] term;

    always_comb begin
        case (tad.sel)
            SEL_DIV2: term = TERM_DIV2;
            SEL_DIV4: term = TERM_DIV4;
            SEL_DIV8: term = TERM_DIV8;
            SEL_DIV16: term = TERM_DIV16;
            SEL_DIV32: term = TERM_DIV32;
            SEL_DIV64: term = TERM_DIV64;
            default: term = TERM_DIV2;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (!tad.run) begin
            st_d.cnt = 6'h00;
        end else if (tad.sel[1:0] == 2'b11) begin
            st_d.tick = rc_tick;
        end else if (st_q.cnt == term) begin
            st_d.cnt = 6'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign tad.tick = st_q.tick;

endmodule // conv_clock_div

// file: logic/adc_config_control.sv
// Purpose: control registers, sequencing and result formatting for a 10-bit converter
// Assumes: analogue core drives core_result valid at the last bit period
// Notes: registers reached over Avalon-MM, one wait cycle per access
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module adc_config_control
    import adc_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [adc_cfg_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [adc_cfg_pkg::DATA_W-1:0] avs_writedata,
    output logic [adc_cfg_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rc_tick,
    input wire logic [adc_cfg_pkg::RES_W-1:0] core_result,
    input wire logic sleep_active,
    input wire logic global_irq_en,
    input wire logic instr_retired,
    output logic [2:0] analog_channel,
    output logic ref_external,
    output logic sample_enable,
    output logic convert_active,
    output logic bit_strobe,
    output logic converter_irq,
    output logic wake_req,
    output logic isr_vector,
    output logic resume_inline
);
    import adc_cfg_pkg::*;

    typedef struct packed {
        logic wait_n;
        logic [DATA_W-1:0] rdata;
        logic conv_on;
        logic go;
        logic [2:0] chan;
        logic ref_ext;
        logic justify;
        logic [2:0] clksel;
        logic done;
        logic ie;
        logic [RES_W-1:0] result;
        phase_e phase;
        logic [3:0] cnt;
        logic strobe;
        logic irq;
        logic wake;
        logic wake_pend;
        logic vec;
        logic inl;
    } ctl_s;

    ctl_s st_q;
    ctl_s st_d;
    logic [1:0] rst_sync_q;
    logic rst_sync_n;
    logic req;
    logic commit_wr;
    logic tick;

    tad_if u_tad ();

    // reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_q[1];

    conv_clock_div u_div (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .clk_en(clk_en),
        .rc_tick(rc_tick),
        .tad(u_tad.div)
    );

    assign u_tad.run = (st_q.phase == PH_CONV) || (st_q.phase == PH_HOLD);
    assign u_tad.sel = st_q.clksel;
    assign tick = u_tad.tick;

    assign req = avs_read || avs_write;
    // write takes effect at the edge where waitrequest is seen low
    assign commit_wr = avs_write && st_q.wait_n;

    function automatic logic [DATA_W-1:0] read_word(input ctl_s s, input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = '0;
        case (a)
            OFS_CTRL0: begin
                w[POS_ON] = s.conv_on;
                w[POS_GO] = s.go;
                w[POS_CHAN +: 3] = s.chan;
                w[POS_REF] = s.ref_ext;
                w[POS_JUSTIFY] = s.justify;
            end
            OFS_CTRL1: w[POS_CLKSEL +: 3] = s.clksel;
            OFS_IRQ: begin
                w[POS_DONE] = s.done;
                w[POS_IE] = s.ie;
            end
            OFS_RES_HIGH: begin
                if (s.justify) begin
                    w[1:0] = s.result[9:8];
                end else begin
                    w[7:0] = s.result[9:2];
                end
            end
            OFS_RES_LOW: begin
                if (s.justify) begin
                    w[7:0] = s.result[7:0];
                end else begin
                    w[7:6] = s.result[1:0];
                end
            end
            default: w = '0;
        endcase
        return w;
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.strobe = 1'b0;
        st_d.vec = 1'b0;
        st_d.inl = 1'b0;

        // bus handshake: one wait cycle, then one cycle with waitrequest low
        st_d.wait_n = req && !st_q.wait_n;
        if (avs_read && !st_q.wait_n) begin
            st_d.rdata = read_word(st_q, avs_address);
        end

        // software register writes
        if (commit_wr) begin
            case (avs_address)
                OFS_CTRL0: begin
                    st_d.conv_on = avs_writedata[POS_ON];
                    st_d.chan = avs_writedata[POS_CHAN +: 3];
                    st_d.ref_ext = avs_writedata[POS_REF];
                    st_d.justify = avs_writedata[POS_JUSTIFY];
                    st_d.go = avs_writedata[POS_GO] && avs_writedata[POS_ON] && st_q.conv_on;
                end
                OFS_CTRL1: st_d.clksel = avs_writedata[POS_CLKSEL +: 3];
                OFS_IRQ: begin
                    st_d.ie = avs_writedata[POS_IE];
                    if (!avs_writedata[POS_DONE]) begin
                        st_d.done = 1'b0;
                    end
                end
                default: st_d.done = st_q.done;
            endcase
        end

        // conversion sequencing
        case (st_q.phase)
            PH_OFF: begin
                if (st_d.conv_on) begin
                    st_d.phase = PH_ACQ;
                end
            end
            PH_ACQ: begin
                if (st_d.go) begin
                    st_d.phase = PH_CONV;
                    st_d.cnt = 4'h0;
                end
            end
            PH_CONV: begin
                if (!st_d.go) begin
                    st_d.phase = PH_HOLD;
                    st_d.cnt = 4'h0;
                end else if (tick) begin
                    st_d.strobe = 1'b1;
                    if (st_q.cnt == CONV_PERIODS - 4'h1) begin
                        st_d.phase = PH_ACQ;
                        st_d.go = 1'b0;
                        st_d.result = core_result;
                        st_d.done = 1'b1;
                    end else begin
                        st_d.cnt = st_q.cnt + 4'h1;
                    end
                end
            end
            PH_HOLD: begin
                st_d.go = 1'b0;
                if (tick) begin
                    if (st_q.cnt == HOLD_PERIODS - 4'h1) begin
                        st_d.phase = PH_ACQ;
                    end else begin
                        st_d.cnt = st_q.cnt + 4'h1;
                    end
                end
            end
            default: st_d.phase = PH_OFF;
        endcase
        if (!st_d.conv_on) begin
            st_d.phase = PH_OFF;
            st_d.go = 1'b0;
        end

        // interrupt, wake and resume
        st_d.irq = st_d.done && st_d.ie;
        st_d.wake = sleep_active && st_q.irq;
        if (st_d.wake && !st_q.wake) begin
            st_d.wake_pend = 1'b1;
        end else if (st_q.wake_pend && instr_retired) begin
            st_d.wake_pend = 1'b0;
            st_d.vec = global_irq_en;
            st_d.inl = !global_irq_en;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q <= '0;
            st_q.wait_n <= 1'b0;
            st_q.conv_on <= RST_ON;
            st_q.chan <= RST_CHAN;
            st_q.ref_ext <= RST_REF;
            st_q.justify <= RST_JUSTIFY;
            st_q.clksel <= RST_CLKSEL;
            st_q.phase <= PH_OFF;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = !st_q.wait_n;
    assign analog_channel = st_q.chan;
    assign ref_external = st_q.ref_ext;
    assign sample_enable = (st_q.phase == PH_ACQ);
    assign convert_active = (st_q.phase == PH_CONV);
    assign bit_strobe = st_q.strobe;
    assign converter_irq = st_q.irq;
    assign wake_req = st_q.wake;
    assign isr_vector = st_q.vec;
    assign resume_inline = st_q.inl;

    // helper: bit periods seen in the current conversion
    logic [3:0] help_ticks_q;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            help_ticks_q <= 4'h0;
        end else if (clk_en) begin
            if (st_q.phase != PH_CONV) begin
                help_ticks_q <= 4'h0;
            end else if (tick) begin
                help_ticks_q <= help_ticks_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_ctrl0_write;
        clk_en && commit_wr && avs_address == OFS_CTRL0;
    endsequence

    sequence s_read_high_left;
        clk_en && avs_read && !st_q.wait_n && avs_address == OFS_RES_HIGH && !st_q.justify;
    endsequence

    sequence s_finish;
        clk_en && st_q.phase == PH_CONV && st_q.go && tick && st_q.cnt == CONV_PERIODS - 4'h1;
    endsequence

    a_chan_route: assert property (s_ctrl0_write |=> analog_channel == $past(avs_writedata[4:2]))
        else $error("channel output does not follow written field");
    a_go_needs_on: assert property ($rose(st_q.go) |-> $past(st_q.conv_on) && st_q.conv_on)
        else $error("go set while converter off");
    a_conv_length: assert property ($rose(st_q.done) |-> help_ticks_q == CONV_PERIODS)
        else $error("conversion did not last eleven bit periods");
    a_finish_effects: assert property (s_finish |=> st_q.done && !st_q.go && st_q.result == $past(core_result))
        else $error("completion effects missing");
    a_flag_sticky: assert property (st_q.done && !(clk_en && commit_wr && avs_address == OFS_IRQ
        && !avs_writedata[0]) |=> st_q.done)
        else $error("done flag cleared without software write");
    a_abort_keeps: assert property (st_q.phase == PH_CONV ##1 st_q.phase == PH_HOLD |-> $stable(st_q.result))
        else $error("result changed on abort");
    a_hold_two: assert property (clk_en && st_q.phase == PH_HOLD && tick && st_q.cnt == 4'h1
        && st_q.conv_on && !commit_wr |=> st_q.phase == PH_ACQ)
        else $error("hold did not end after two bit periods");
    a_irq_level: assert property (converter_irq == (st_q.done && st_q.ie))
        else $error("interrupt request differs from flag and enable");
    a_wake_sleep: assert property (clk_en && sleep_active && converter_irq |=> wake_req)
        else $error("no wake for interrupt in sleep");
    a_left_justify: assert property (s_read_high_left |=> avs_readdata[7:0] == st_q.result[9:2])
        else $error("left justified high byte wrong");

endmodule // adc_config_control

// file: test/adc_core_model.sv
// Purpose: analogue core stand-in: result per channel and reference, rc oscillator
// Assumes: result read by the block only while convert_active is high
// Notes: outside conversion the result lines show the inverse level
`timescale 1ns/1ps
module adc_core_model
    import adc_cfg_pkg::*;
#(
    parameter int RC_PER = 5
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] analog_channel,
    input wire logic ref_external,
    input wire logic convert_active,
    output logic [adc_cfg_pkg::RES_W-1:0] core_result,
    output logic rc_tick
);
    logic [RES_W-1:0] level;
    int rc_cnt;
    // level seen through the selected channel and reference
    assign level = {ref_external, analog_channel, ~analog_channel, analog_channel};
    assign core_result = convert_active ? level : ~level;
    // free-running dedicated oscillator, one tick every RC_PER system clock cycles
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_cnt <= 0;
            rc_tick <= 1'b0;
        end else begin
            rc_cnt <= (rc_cnt == RC_PER - 1) ? 0 : rc_cnt + 1;
            rc_tick <= (rc_cnt == RC_PER - 1);
        end
    end
endmodule // adc_core_model

// file: test/tb_adc_config_control.sv
// Purpose: self-checking bench for the converter control block
// Assumes: one wait cycle per bus access, rc tick every RC_PER cycles
// Notes: software side waits settling and picks legal clocks
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_adc_config_control;
    import adc_cfg_pkg::*;
    localparam int RC_PER = 5;
    logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, rc_tick;
    logic sleep_active, global_irq_en, instr_retired;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, d;
    logic [RES_W-1:0] core_result;
    logic [2:0] analog_channel;
    logic ref_external, sample_enable, convert_active, bit_strobe;
    logic converter_irq, wake_req, isr_vector, resume_inline;
    logic [16:0] seed = 17'd95329;
    logic [31:0] exp_hi, exp_lo;
    int n_errors = 0, cmp_count = 0, cycles = 0, gap = 0, last_gap = 0, n_strobe = 0, k;

    adc_config_control adc_config_control_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rc_tick(rc_tick), .core_result(core_result), .sleep_active(sleep_active),
        .global_irq_en(global_irq_en), .instr_retired(instr_retired), .analog_channel(analog_channel),
        .ref_external(ref_external), .sample_enable(sample_enable), .convert_active(convert_active),
        .bit_strobe(bit_strobe), .converter_irq(converter_irq), .wake_req(wake_req),
        .isr_vector(isr_vector), .resume_inline(resume_inline));
    adc_core_model #(.RC_PER(RC_PER)) adc_core_model_i (.core_clk(core_clk), .rst_n(rst_n),
        .analog_channel(analog_channel), .ref_external(ref_external), .convert_active(convert_active),
        .core_result(core_result), .rc_tick(rc_tick));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    function automatic int div_of(input logic [2:0] s);
        case (s)
            3'h0: return 2;
            3'h4: return 4;
            3'h1: return 8;
            3'h5: return 16;
            3'h2: return 32;
            3'h6: return 64;
            default: return RC_PER;
        endcase
    endfunction

    task automatic results();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // strobe spacing and count, in core clock cycles
    always @(posedge core_clk) begin
        cycles++;
        gap++;
        if (bit_strobe === 1'b1) begin
            n_strobe++;
            last_gap = gap;
            gap = 0;
        end
        if (cycles == 30000) begin
            n_errors++;
            results();
        end
    end

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        d = avs_readdata;
        if (n >= 50) n_errors++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic convert(input logic [2:0] sel);
        logic [31:0] c0;
        logic [9:0] r;
        seed = lfsr(seed);
        c0 = {24'h0, seed[4], seed[3], 1'b0, seed[2:0], 2'b01};
        r = {seed[3], seed[2:0], ~seed[2:0], seed[2:0]};
        bus(1, OFS_CTRL1, {25'h0, sel, 4'h0});
        bus(1, OFS_CTRL0, c0);
        `CHK(analog_channel, seed[2:0])
        `CHK(ref_external, seed[3])
        n_strobe = 0;
        bus(1, OFS_CTRL0, c0 | 32'h2);
        k = 0;
        do begin
            bus(0, OFS_CTRL0, 32'h0);
            k++;
        end while (d[1] !== 1'b0 && k < 400);
        `CHK(n_strobe, 11)
        `CHK(last_gap, div_of(sel))
        exp_hi = seed[4] ? 32'(r[9:8]) : 32'(r[9:2]);
        exp_lo = seed[4] ? 32'(r[7:0]) : 32'({r[1:0], 6'h0});
        bus(0, OFS_RES_HIGH, 32'h0);
        `CHK(d, exp_hi)
        bus(0, OFS_RES_LOW, 32'h0);
        `CHK(d, exp_lo)
        bus(0, OFS_IRQ, 32'h0);
        `CHK(d[0], 1'b1)
    endtask

    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        sleep_active = 1'b0;
        global_irq_en = 1'b0;
        instr_retired = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int a = 0; a < 24; a += 4) begin
            bus(0, 5'(a), 32'h0);
            `CHK(d, 32'h0)
        end
        bus(1, OFS_CTRL0, 32'h0000_0002);
        bus(0, OFS_CTRL0, 32'h0);
        `CHK(d, 32'h0)
        for (int s = 0; s < 8; s++) begin
            convert(3'(s));
        end
        `CHK(converter_irq, 1'b0)
        bus(1, OFS_IRQ, 32'h0000_0003);
        bus(0, OFS_IRQ, 32'h0);
        `CHK(d, 32'h0000_0003)
        `CHK(converter_irq, 1'b1)
        bus(1, OFS_IRQ, 32'h0000_0002);
        bus(0, OFS_IRQ, 32'h0);
        `CHK(d, 32'h0000_0002)
        `CHK(converter_irq, 1'b0)
        for (int g = 0; g < 2; g++) begin
            global_irq_en <= g[0];
            sleep_active <= 1'b1;
            convert(3'h7);
            `CHK(wake_req, 1'b1)
            instr_retired <= 1'b1;
            @(posedge core_clk);
            instr_retired <= 1'b0;
            #1;
            `CHK(isr_vector, g[0])
            `CHK(resume_inline, !g[0])
            @(posedge core_clk);
            sleep_active <= 1'b0;
            bus(1, OFS_IRQ, 32'h0000_0002);
        end
        bus(1, OFS_CTRL1, 32'h0000_0060);
        bus(1, OFS_CTRL0, 32'h0000_0003 | (32'(seed[4]) << 7));
        n_strobe = 0;
        k = 0;
        while (n_strobe < 3 && k < 500) begin
            @(posedge core_clk);
            k++;
        end
        bus(1, OFS_CTRL0, 32'h0000_0001 | (32'(seed[4]) << 7));
        k = 0;
        while (sample_enable !== 1'b1 && k < 300) begin
            @(posedge core_clk);
            k++;
        end
        `CHK(k >= 100 && k <= 140, 1'b1)
        bus(0, OFS_RES_HIGH, 32'h0);
        `CHK(d, exp_hi)
        bus(0, OFS_RES_LOW, 32'h0);
        `CHK(d, exp_lo)
        bus(0, OFS_IRQ, 32'h0);
        `CHK(d[0], 1'b0)
        results();
    end
endmodule // tb_adc_config_control
